// ---- logic/fsmc_defs.svh ----
// Register map, field positions, reset values and timing counts
`ifndef FSMC_DEFS_SVH
`define FSMC_DEFS_SVH

`define FSMC_OFS_STATUS 12'h000
`define FSMC_OFS_MARGIN 12'h004
`define FSMC_OFS_MODE 12'h008
`define FSMC_OFS_IRQ_STS 12'h00c
`define FSMC_OFS_IRQ_MASK 12'h010

`define FSMC_KEY_READ 8'h96
`define FSMC_KEY_WRITE 8'ha5

`define FSMC_ST_PROTECT 6
`define FSMC_ST_EXIT 5
`define FSMC_ST_LOCK 4
`define FSMC_ST_WAIT 3
`define FSMC_ST_ACCV 2
`define FSMC_ST_PWVIO 1
`define FSMC_ST_BUSY 0

`define FSMC_MD_BLOCK 7
`define FSMC_MD_WRITE 6
`define FSMC_MD_GLOBAL 3
`define FSMC_MD_MASS 2
`define FSMC_MD_ERASE 1

`define FSMC_MG_ONE 5
`define FSMC_MG_ZERO 4

`define FSMC_PROTECT_RST 1'b1
`define FSMC_LOCK_RST 1'b1
`define FSMC_WAIT_RST 1'b1

`define FSMC_EV_WRITE 0
`define FSMC_EV_ERASE 1
`define FSMC_EV_ACCV 2
`define FSMC_EV_PASSWORD_VIOLATION 3

`define FSMC_CLK_NS 4
`define FSMC_WRITE_NS 120
`define FSMC_ERASE_NS 12000
`define FSMC_WRITE_CYC \
  ((`FSMC_WRITE_NS + `FSMC_CLK_NS - 1) / `FSMC_CLK_NS)
`define FSMC_ERASE_CYC \
  ((`FSMC_ERASE_NS + `FSMC_CLK_NS - 1) / `FSMC_CLK_NS)

`endif

// ---- logic/fsmc_pkg.sv ----
// Types shared by the flash status and margin controller
package fsmc_pkg;
  typedef enum logic [2:0] {
    R_STATUS, R_MARGIN, R_MODE, R_IRQ_STS, R_IRQ_MASK, R_NONE
  } fsmc_reg_e;
  typedef enum {ST_IDLE, ST_WRITE, ST_BLOCK_WAIT, ST_ERASE} fsmc_state_e;
  typedef logic [11:0] fsmc_cnt_t;
endpackage

// ---- logic/fsmc_timing_gen.sv ----
// Flash timing generator: times one write or erase pulse
`timescale 1ns/1ns
`default_nettype none
`include "fsmc_defs.svh"
module fsmc_timing_gen
  import fsmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  input wire logic is_erase,
  output logic busy,
  output logic done
);
  fsmc_cnt_t cnt;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      cnt <= '0;
    end
    else if (abort)
    begin
      busy <= 1'b0;
      cnt <= '0;
    end
    else if (start)
    begin
      busy <= 1'b1;
      cnt <= is_erase ? 12'(`FSMC_ERASE_CYC - 1) : 12'(`FSMC_WRITE_CYC - 1);
    end
    else if (busy)
    begin
      if (cnt == '0)
        busy <= 1'b0;
      else
        cnt <= cnt - 12'h001;
    end
  end

  // Done marks the last busy cycle so the sequencer leaves with busy
  assign done = busy && (cnt == '0) && !abort;
endmodule
`default_nettype wire

// ---- logic/fsmc_top.sv ----
// Flash status, protection and marginal-read control with APB access
// Behaviour
// - Writing 1 toggles info-segment protect; writing 0 leaves it.
// - Mass erase spares info memory while protect is set.
// - Emergency-exit bit at status bit 5 aborts the flash operation.
// - Write or erase starts only while the lock bit is clear.
// - Setting lock mid write or erase lets it finish.
// - Lock during block wait clears block mode and ready, ends cleanly.
// - Ready bit sets when a write finishes; clears when a write starts or block wait ends.
// - Access-violation flag at bit 2 records a refused access until a status write clears it.
// - Wrong password sets key-violation and forces power-up clear.
// - Busy bit mirrors the timing generator activity.
// - Password byte reads 96h; writes need A5h.
// - Emergency exit clears block, write and erase selections.
// - With both margin bits set, margin-one wins.
// - CPU fetch from flash clears both margin bits.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "fsmc_defs.svh"
module fsmc_top
  import fsmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic flash_access,
  input wire logic cpu_fetch_flash,
  output logic flash_busy,
  output logic erase_info_enable,
  output logic erase_all_arrays,
  output logic margin_one_active,
  output logic margin_zero_active,
  output logic power_up_clear_reset,
  output logic irq
);
  import fsmc_pkg::*;

  function automatic fsmc_reg_e reg_decode(input logic [11:0] a);
    unique case (a)
      `FSMC_OFS_STATUS: reg_decode = R_STATUS;
      `FSMC_OFS_MARGIN: reg_decode = R_MARGIN;
      `FSMC_OFS_MODE: reg_decode = R_MODE;
      `FSMC_OFS_IRQ_STS: reg_decode = R_IRQ_STS;
      `FSMC_OFS_IRQ_MASK: reg_decode = R_IRQ_MASK;
      default: reg_decode = R_NONE;
    endcase
  endfunction

  function automatic logic is_keyed(input fsmc_reg_e r);
    is_keyed = (r == R_STATUS) || (r == R_MARGIN) || (r == R_MODE);
  endfunction

  fsmc_state_e state;
  fsmc_reg_e sel;
  logic acc;
  logic wr_fire;
  logic key_ok;
  logic key_bad;
  logic wr_status;
  logic wr_margin;
  logic wr_mode;
  logic wr_irq_sts;
  logic wr_irq_mask;
  logic info_segment_protect;
  logic emergency_exit;
  logic lock;
  logic wait_ready;
  logic access_violation_flag;
  logic password_violation;
  logic block_write_mode;
  logic write_select;
  logic global_mass_erase;
  logic mass_erase_select;
  logic erase_bit;
  logic margin_one_read;
  logic margin_zero_read;
  logic [3:0] irq_sts;
  logic [3:0] irq_mask;
  logic [3:0] events;
  logic erase_sel;
  logic op_running;
  logic start_write;
  logic start_erase;
  logic write_done;
  logic erase_done;
  logic blk_end;
  logic av_set;
  logic tg_done;
  logic [31:0] rd_val;

  // APB decode; every access takes exactly one wait state
  assign sel = reg_decode(paddr);
  assign acc = psel && penable;
  assign wr_fire = acc && pready && pwrite && (sel != R_NONE);
  assign key_ok = pwdata[15:8] == `FSMC_KEY_WRITE;
  assign key_bad = wr_fire && is_keyed(sel) && !key_ok;
  assign wr_status = wr_fire && (sel == R_STATUS) && key_ok;
  assign wr_margin = wr_fire && (sel == R_MARGIN) && key_ok;
  assign wr_mode = wr_fire && (sel == R_MODE) && key_ok;
  assign wr_irq_sts = wr_fire && (sel == R_IRQ_STS);
  assign wr_irq_mask = wr_fire && (sel == R_IRQ_MASK);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pready <= 1'b0;
    else
      pready <= acc && !pready;
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (sel)
      R_STATUS:
      begin
        rd_val[15:8] = `FSMC_KEY_READ;
        rd_val[`FSMC_ST_PROTECT] = info_segment_protect;
        rd_val[`FSMC_ST_EXIT] = emergency_exit;
        rd_val[`FSMC_ST_LOCK] = lock;
        rd_val[`FSMC_ST_WAIT] = wait_ready;
        rd_val[`FSMC_ST_ACCV] = access_violation_flag;
        rd_val[`FSMC_ST_PWVIO] = password_violation;
        rd_val[`FSMC_ST_BUSY] = flash_busy;
      end
      R_MARGIN:
      begin
        // Bits 7, 6 and 3..0 stay zero
        rd_val[15:8] = `FSMC_KEY_READ;
        rd_val[`FSMC_MG_ONE] = margin_one_read;
        rd_val[`FSMC_MG_ZERO] = margin_zero_read;
      end
      R_MODE:
      begin
        rd_val[15:8] = `FSMC_KEY_READ;
        rd_val[`FSMC_MD_BLOCK] = block_write_mode;
        rd_val[`FSMC_MD_WRITE] = write_select;
        rd_val[`FSMC_MD_GLOBAL] = global_mass_erase;
        rd_val[`FSMC_MD_MASS] = mass_erase_select;
        rd_val[`FSMC_MD_ERASE] = erase_bit;
      end
      R_IRQ_STS: rd_val[3:0] = irq_sts;
      R_IRQ_MASK: rd_val[3:0] = irq_mask;
      R_NONE: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (acc && !pready)
    begin
      prdata <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= sel == R_NONE;
    end
  end

  // Flash sequencing
  assign erase_sel = mass_erase_select || erase_bit;
  assign op_running = (state == ST_WRITE) || (state == ST_ERASE);
  assign blk_end = (state == ST_BLOCK_WAIT) && !emergency_exit &&
                   (lock || !block_write_mode);
  assign start_write = flash_access && !lock && !emergency_exit &&
                       write_select && !erase_sel && !blk_end &&
                       ((state == ST_IDLE) ||
                        (state == ST_BLOCK_WAIT));
  assign start_erase = flash_access && !lock && !emergency_exit &&
                       erase_sel && (state == ST_IDLE);
  assign write_done = (state == ST_WRITE) && tg_done;
  assign erase_done = (state == ST_ERASE) && tg_done;
  // A locked or overlapping access is refused and flagged
  assign av_set = flash_access && !emergency_exit &&
                  (lock || op_running);

  fsmc_timing_gen u_tg (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(start_write || start_erase),
    .abort(emergency_exit),
    .is_erase(start_erase),
    .busy(flash_busy),
    .done(tg_done)
  );

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else if (emergency_exit)
      state <= ST_IDLE;
    else
    begin
      // Lock is not checked here so a running operation completes
      unique case (state)
        ST_IDLE:
          if (start_write)
            state <= ST_WRITE;
          else if (start_erase)
            state <= ST_ERASE;
        ST_WRITE:
          if (tg_done)
            state <= (block_write_mode && write_select) ?
                     ST_BLOCK_WAIT : ST_IDLE;
        ST_BLOCK_WAIT:
          if (blk_end)
            state <= ST_IDLE;
          else if (start_write)
            state <= ST_WRITE;
        ST_ERASE:
          if (tg_done)
            state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      wait_ready <= `FSMC_WAIT_RST;
    else if (blk_end || start_write)
      wait_ready <= 1'b0;
    else if (write_done)
      wait_ready <= 1'b1;
  end

  // Erase scope is latched so protect changes mid erase do not matter
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      erase_info_enable <= 1'b0;
      erase_all_arrays <= 1'b0;
    end
    else if (start_erase)
    begin
      erase_info_enable <= mass_erase_select && erase_bit &&
                           !info_segment_protect;
      erase_all_arrays <= mass_erase_select && global_mass_erase;
    end
  end

  // Status register bits
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      info_segment_protect <= `FSMC_PROTECT_RST;
      emergency_exit <= 1'b0;
      lock <= `FSMC_LOCK_RST;
    end
    else if (wr_status)
    begin
      if (pwdata[`FSMC_ST_PROTECT])
        info_segment_protect <= !info_segment_protect;
      emergency_exit <= pwdata[`FSMC_ST_EXIT];
      lock <= pwdata[`FSMC_ST_LOCK];
    end
  end

  // Hardware sets win over a software clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      access_violation_flag <= 1'b0;
      password_violation <= 1'b0;
      power_up_clear_reset <= 1'b0;
    end
    else
    begin
      access_violation_flag <= av_set ||
        (wr_status ? pwdata[`FSMC_ST_ACCV] : access_violation_flag);
      password_violation <= key_bad || (password_violation &&
        !(wr_status && !pwdata[`FSMC_ST_PWVIO]));
      power_up_clear_reset <= key_bad;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      block_write_mode <= 1'b0;
      write_select <= 1'b0;
      global_mass_erase <= 1'b0;
      mass_erase_select <= 1'b0;
      erase_bit <= 1'b0;
    end
    else if (emergency_exit)
    begin
      block_write_mode <= 1'b0;
      write_select <= 1'b0;
      global_mass_erase <= 1'b0;
      mass_erase_select <= 1'b0;
      erase_bit <= 1'b0;
    end
    else
    begin
      if (wr_mode)
      begin
        block_write_mode <= pwdata[`FSMC_MD_BLOCK];
        write_select <= pwdata[`FSMC_MD_WRITE];
        global_mass_erase <= pwdata[`FSMC_MD_GLOBAL];
        mass_erase_select <= pwdata[`FSMC_MD_MASS];
        erase_bit <= pwdata[`FSMC_MD_ERASE];
      end
      if (erase_done)
      begin
        global_mass_erase <= 1'b0;
        mass_erase_select <= 1'b0;
        erase_bit <= 1'b0;
      end
      if (blk_end && lock)
        block_write_mode <= 1'b0;
    end
  end

  // A fetch from flash outranks a simultaneous margin write
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      margin_one_read <= 1'b0;
      margin_zero_read <= 1'b0;
    end
    else if (cpu_fetch_flash)
    begin
      margin_one_read <= 1'b0;
      margin_zero_read <= 1'b0;
    end
    else if (wr_margin)
    begin
      margin_one_read <= pwdata[`FSMC_MG_ONE];
      margin_zero_read <= pwdata[`FSMC_MG_ZERO];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      margin_one_active <= 1'b0;
      margin_zero_active <= 1'b0;
    end
    else
    begin
      margin_one_active <= margin_one_read;
      margin_zero_active <= margin_zero_read && !margin_one_read;
    end
  end

  // Interrupt events, write-one-to-clear, set wins
  assign events = {key_bad, av_set, erase_done, write_done};

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_sts <= 4'h0;
      irq_mask <= 4'h0;
      irq <= 1'b0;
    end
    else
    begin
      irq_sts <= (irq_sts & ~(wr_irq_sts ? pwdata[3:0] : 4'h0)) | events;
      if (wr_irq_mask)
        irq_mask <= pwdata[3:0];
      irq <= |(irq_sts & irq_mask);
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_protect_toggle: assert property (wr_status && pwdata[6] |=>
    info_segment_protect != $past(info_segment_protect))
    else $error("protect bit did not toggle");
  a_protect_hold: assert property (wr_status && !pwdata[6] |=>
    $stable(info_segment_protect))
    else $error("protect bit changed on zero write");
  a_lock_refuse: assert property (flash_access && lock &&
    state == ST_IDLE && !emergency_exit |=>
    state == ST_IDLE && access_violation_flag)
    else $error("locked flash accepted an operation");
  a_lock_finish: assert property (state == ST_ERASE && lock &&
    !emergency_exit && !tg_done |=> state == ST_ERASE)
    else $error("lock aborted an erase");
  a_block_end: assert property (state == ST_BLOCK_WAIT && lock &&
    !emergency_exit |=> state == ST_IDLE && !block_write_mode &&
    !wait_ready)
    else $error("block mode not ended by lock");
  a_ready_write: assert property (state == ST_WRITE |-> !wait_ready)
    else $error("ready shown during write");
  a_key_reset: assert property (key_bad |=> power_up_clear_reset &&
    password_violation ##1 !power_up_clear_reset)
    else $error("bad password missed reset pulse");
  a_busy_state: assert property (flash_busy == op_running)
    else $error("busy bit disagrees with sequencer");
  a_key_read: assert property (acc && pready && !pwrite &&
    is_keyed(sel) |-> prdata[15:8] == 8'h96)
    else $error("password byte read wrong");
  a_exit_clear: assert property (emergency_exit |=> !block_write_mode &&
    !write_select && !erase_sel && state == ST_IDLE)
    else $error("emergency exit left modes set");
  a_margin_prio: assert property (margin_one_read && margin_zero_read |=>
    margin_one_active && !margin_zero_active)
    else $error("margin priority wrong");
  a_fetch_clear: assert property (cpu_fetch_flash |=>
    !margin_one_read && !margin_zero_read ##1
    !margin_one_active && !margin_zero_active)
    else $error("fetch did not clear margin mode");
endmodule
`default_nettype wire

// ---- verif/flash_status_margin_control_bench.sv ----
// Self-checking bench for the flash status and margin controller
`timescale 1ns/1ns
`default_nettype none
`include "fsmc_defs.svh"
module flash_status_margin_control_bench;
  localparam logic [11:0] o_st = `FSMC_OFS_STATUS;
  localparam logic [11:0] o_mg = `FSMC_OFS_MARGIN;
  localparam logic [11:0] o_md = `FSMC_OFS_MODE;
  localparam logic [11:0] o_is = `FSMC_OFS_IRQ_STS;
  localparam logic [11:0] o_im = `FSMC_OFS_IRQ_MASK;
  localparam logic [31:0] m_all = 32'hffff_ffff;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic pready, pslverr, rerr, flash_access, cpu_fetch_flash, flash_busy;
  logic erase_info_enable, erase_all_arrays, irq, power_up_clear_reset;
  logic margin_one_active, margin_zero_active;
  int mismatches = 0;
  int n_checks = 0;
  int n_clr_pulse = 0;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (power_up_clear_reset === 1'b1)
      n_clr_pulse <= n_clr_pulse + 1;
  fsmc_top uut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .flash_access(flash_access),
    .cpu_fetch_flash(cpu_fetch_flash),
    .flash_busy(flash_busy),
    .erase_info_enable(erase_info_enable),
    .erase_all_arrays(erase_all_arrays),
    .margin_one_active(margin_one_active),
    .margin_zero_active(margin_zero_active),
    .power_up_clear_reset(power_up_clear_reset),
    .irq(irq)
  );
  fsmc_flash_model cpu (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .flash_busy(flash_busy),
    .flash_access(flash_access),
    .cpu_fetch_flash(cpu_fetch_flash)
  );
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic fail(input string m);
    mismatches++;
    $display("Error at %0t: %s", $time, m);
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e,
                         input logic [31:0] m);
    n_checks++;
    if ((g & m) !== (e & m))
      fail($sformatf("register got %h want %h", g, e));
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    n_checks++;
    if (g !== e)
      fail(m);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Request stays put until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge ref_clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      fail("bus timeout");
      give_verdict();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk_reg(rdat, e, m);
  endtask
  task automatic wait_busy(input logic v, input int n);
    int i;
    for (i = 0; i < n && flash_busy !== v; i++)
      @(posedge ref_clk);
    if (flash_busy !== v)
    begin
      fail("busy wait timeout");
      give_verdict();
    end
  endtask
  task automatic t_reset();
    rd(o_st, 32'h9658, m_all);
    rd(o_mg, 32'h9600, m_all);
    rd(12'h020, 32'h0, m_all);
    chk_bit(rerr, 1'b1, "unmapped address accepted");
    $display("reset test done");
  endtask
  task automatic t_protect();
    wr(o_st, 32'ha550);
    rd(o_st, 32'h9618, m_all);
    wr(o_st, 32'ha510);
    rd(o_st, 32'h9618, m_all);
    wr(o_st, 32'ha550);
    rd(o_st, 32'h9658, m_all);
    $display("protect test done");
  endtask
  task automatic t_password();
    int p;
    p = n_clr_pulse;
    wr(o_mg, 32'h5a30);
    tick(3);
    chk_bit(n_clr_pulse == p + 1, 1'b1, "reset pulse missing");
    rd(o_st, 32'h965a, m_all);
    rd(o_mg, 32'h9600, m_all);
    rd(o_is, 32'h8, 32'h8);
    wr(o_is, 32'h8);
    tick(4);
    rd(o_st, 32'h965a, m_all);
    wr(o_st, 32'ha510);
    rd(o_st, 32'h9658, m_all);
    chk_bit(n_clr_pulse == p + 1, 1'b1, "spurious reset pulse");
    $display("password test done");
  endtask
  task automatic t_write();
    wr(o_st, 32'ha500);
    wr(o_md, 32'ha540);
    cpu.access();
    wait_busy(1'b1, 5);
    rd(o_st, 32'h9641, m_all);
    wr(o_st, 32'ha510);
    wait_busy(1'b0, 60);
    tick(1);
    chk_bit(cpu.last_len inside {[`FSMC_WRITE_CYC - 1:`FSMC_WRITE_CYC]},
            1'b1, "write cut short");
    rd(o_st, 32'h9658, m_all);
    rd(o_is, 32'h1, 32'h1);
    $display("write test done");
  endtask
  task automatic t_accv();
    chk_bit(irq, 1'b0, "irq while masked");
    cpu.access();
    tick(3);
    chk_bit(flash_busy, 1'b0, "locked access started");
    rd(o_st, 32'h965c, m_all);
    wr(o_im, 32'h4);
    tick(3);
    chk_bit(irq, 1'b1, "irq not raised");
    wr(o_is, 32'h4);
    tick(3);
    chk_bit(irq, 1'b0, "irq not cleared");
    wr(o_st, 32'ha510);
    rd(o_st, 32'h9658, m_all);
    $display("violation test done");
  endtask
  task automatic t_block();
    wr(o_st, 32'ha500);
    wr(o_md, 32'ha5c0);
    cpu.access();
    wait_busy(1'b1, 5);
    wait_busy(1'b0, 60);
    rd(o_st, 32'h9648, m_all);
    wr(o_st, 32'ha510);
    rd(o_st, 32'h9650, m_all);
    rd(o_md, 32'h0, 32'h80);
    $display("block test done");
  endtask
  task automatic t_exit();
    wr(o_st, 32'ha500);
    wr(o_md, 32'ha540);
    cpu.access();
    wait_busy(1'b1, 5);
    wr(o_st, 32'ha520);
    wait_busy(1'b0, 8);
    rd(o_st, 32'h20, 32'h20);
    rd(o_md, 32'h0, 32'hce);
    wr(o_st, 32'ha500);
    $display("exit test done");
  endtask
  // Protect set with plain mass erase, then clear with global erase
  task automatic t_erase();
    logic [7:0] md [2] = '{8'h06, 8'h0e};
    for (int i = 0; i < 2; i++)
    begin
      wr(o_md, {16'h0, 8'ha5, md[i]});
      cpu.access();
      wait_busy(1'b1, 5);
      tick(1);
      chk_bit(erase_info_enable, i == 1, "info erase");
      chk_bit(erase_all_arrays, i == 1, "all arrays");
      // Lock mid erase must not cut the erase short
      wr(o_st, 32'ha510);
      wait_busy(1'b0, 3100);
      rd(o_md, 32'h0, 32'h0e);
      chk_bit(cpu.last_len == `FSMC_ERASE_CYC, 1'b1,
              "erase cut short");
      wr(o_st, 32'ha540);
    end
    wr(o_st, 32'ha510);
    $display("erase test done");
  endtask
  task automatic t_margin();
    wr(o_mg, 32'ha5ff);
    rd(o_mg, 32'h9630, m_all);
    tick(2);
    chk_bit(margin_one_active, 1'b1, "margin one off");
    chk_bit(margin_zero_active, 1'b0, "margin zero on");
    cpu.fetch();
    tick(2);
    rd(o_mg, 32'h9600, m_all);
    chk_bit(margin_one_active, 1'b0, "fetch kept margin");
    wr(o_mg, 32'ha510);
    tick(2);
    chk_bit(margin_zero_active, 1'b1, "margin zero off");
    $display("margin test done");
  endtask
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_protect();
    t_password();
    t_write();
    t_accv();
    t_block();
    t_exit();
    t_erase();
    t_margin();
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- verif/fsmc_flash_model.sv ----
// Far-side model: CPU flash strobes and timing of the busy runs
`timescale 1ns/1ns
`default_nettype none
module fsmc_flash_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic flash_busy,
  output logic flash_access,
  output logic cpu_fetch_flash
);
  int run;
  int last_len;
  initial
  begin
    flash_access = 1'b0;
    cpu_fetch_flash = 1'b0;
  end
  // Strobes last exactly one cycle, as a CPU bus cycle would
  task automatic access();
    @(posedge ref_clk);
    flash_access <= 1'b1;
    @(posedge ref_clk);
    flash_access <= 1'b0;
  endtask
  task automatic fetch();
    @(posedge ref_clk);
    cpu_fetch_flash <= 1'b1;
    @(posedge ref_clk);
    cpu_fetch_flash <= 1'b0;
  endtask
  // Length of the last busy run, kept for the bench to judge
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run <= 0;
      last_len <= 0;
    end
    else if (flash_busy === 1'b1)
      run <= run + 1;
    else if (run != 0)
    begin
      last_len <= run;
      run <= 0;
    end
  end
endmodule
`default_nettype wire
